// ### core/reset_source_sequencer.sv
// Design decisions made here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
// Summary of operation
// - Any reset aborts CPU, loads vector FFFE/FFFF.
// - Reset forces bus clock to reference/4, except low supply on the last hold cycle.
// - Pin held low min time sets pin flag.
// - Internal reset: pin low 32, hold 32.
// - Power-on: gate 4096, pin +32, CPU +64.
// - Power-on sets POR flag, clears others.
// - Low supply holds pin, then power-on timing.
// - Watchdog overflow resets, sets watchdog flag.
// - Any watchdog-location write clears watchdog counter.
// - Bad opcode resets, sets bad opcode flag.
// - Stop with stop disabled counts as bad opcode.
// - Unmapped opcode fetch resets, sets address flag.
// - Unmapped data reads cause no reset.
// - Reading cause register clears flags, nothing else.
// - Flags from several resets accumulate until read.
// - Sample pin 32 cycles after release.
// - Monitor entry reset sets monitor flag.
module reset_source_sequencer
    import reset_seq_pkg::*;
#(
    parameter int MIN_RESET_LOW_NS = 100
)
(
    // Clock and power-on reset
    input wire logic sys_clk,
    input wire logic rst,
    // Avalon-MM register slave
    input wire reset_seq_pkg::av_req_s av_req,
    output reset_seq_pkg::av_rsp_s av_rsp,
    // CPU event strobes, same clock
    input wire reset_seq_pkg::cpu_events_s cpu_events,
    // Low supply detector, asynchronous level
    input wire logic supply_low,
    // Open-drain active-low reset pin
    input wire logic rst_n_pin_in,
    output logic rst_n_pin_out,
    output logic rst_n_pin_oe,
    // Sequencer outputs to CPU and clock tree
    output reset_seq_pkg::seq_out_s seq_out
);
    import reset_seq_pkg::*;

    // Minimum external low time rounded up, never below one cycle
    localparam int MIN_LOW_RAW = (MIN_RESET_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int MIN_LOW_CYC = (MIN_LOW_RAW < 1) ? 1 : MIN_LOW_RAW;
    localparam logic [CNT_W-1:0] MIN_LOW_LAST = CNT_W'(MIN_LOW_CYC - 1);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        seq_state_e st;
        logic [CNT_W-1:0] cnt;
        logic [7:0] flags;
        logic ext_hit;
        logic pin_drive;
        logic [2:0] pin_sync;
        logic pin_lvl;
        logic [2:0] sup_sync;
        logic sup_lvl;
        logic [1:0] div_cnt;
        logic stop_en;
        av_rsp_s rsp;
        seq_out_s out;
    } state_s;

    state_s q;
    state_s d;
    logic [7:0] sets;
    logic commit;
    logic commit_rd_cause;

    function automatic logic at_last(input logic [CNT_W-1:0] cnt, input logic [CNT_W-1:0] last);
        at_last = (cnt == last);
    endfunction

    function automatic logic internal_event(input cpu_events_s ev, input logic stop_en);
        internal_event = ev.watchdog_overflow | ev.bad_opcode | ev.fetch_unmapped
                       | ev.monitor_entry | (ev.stop_executed & ~stop_en);
    endfunction

    // ****************************************************************
    // Next-state logic
    // ****************************************************************
    always_comb
    begin
        d = q;
        sets = 8'h00;
        d.out.vector_load = 1'b0;
        d.out.watchdog_clear = 1'b0;

        // Three-stage pin and supply synchronisers; a level counts when the last two stages agree
        d.pin_sync = {q.pin_sync[1:0], rst_n_pin_in};
        if (q.pin_sync[1] == q.pin_sync[2])
        begin
            d.pin_lvl = q.pin_sync[2];
        end
        d.sup_sync = {q.sup_sync[1:0], supply_low};
        if (q.sup_sync[1] == q.sup_sync[2])
        begin
            d.sup_lvl = q.sup_sync[2];
        end

        // Bus clock enable; restarts at /4 phase while any reset runs
        d.div_cnt = q.div_cnt + 2'h1;
        d.out.bus_clk_en = (q.div_cnt == BUS_DIV_LAST);

        // Sequencer
        unique case (q.st)
            ST_RUN:
            begin
                if (internal_event(cpu_events, q.stop_en))
                begin
                    // Data reads of unmapped space are not an event at all
                    sets[WDOG_BIT] = cpu_events.watchdog_overflow;
                    sets[BAD_OP_BIT] = cpu_events.bad_opcode
                                     | (cpu_events.stop_executed & ~q.stop_en);
                    sets[BAD_FETCH_BIT] = cpu_events.fetch_unmapped;
                    sets[MON_BIT] = cpu_events.monitor_entry;
                    d.st = ST_PIN_LOW;
                    d.cnt = '0;
                    d.pin_drive = 1'b1;
                    d.out.cpu_reset = 1'b1;
                end
                else if (!q.pin_lvl)
                begin
                    d.st = ST_EXT;
                    d.cnt = '0;
                    d.ext_hit = 1'b0;
                end
            end
            ST_EXT:
            begin
                // Short glitches on the pin never reach the CPU
                if (!q.pin_lvl)
                begin
                    if (at_last(q.cnt, MIN_LOW_LAST) && !q.ext_hit)
                    begin
                        sets[PIN_BIT] = 1'b1;
                        d.ext_hit = 1'b1;
                        d.out.cpu_reset = 1'b1;
                    end
                    else if (!q.ext_hit)
                    begin
                        d.cnt = q.cnt + 1'b1;
                    end
                end
                else if (q.ext_hit)
                begin
                    d.st = ST_HOLD;
                    d.cnt = '0;
                end
                else
                begin
                    d.st = ST_RUN;
                end
            end
            ST_SUPPLY:
            begin
                if (!q.sup_lvl)
                begin
                    d.st = ST_STAB;
                    d.cnt = '0;
                end
            end
            ST_STAB:
            begin
                d.cnt = q.cnt + 1'b1;
                if (at_last(q.cnt, STAB_LAST))
                begin
                    d.st = ST_PIN_LOW;
                    d.cnt = '0;
                    d.out.clocks_gated = 1'b0;
                end
            end
            ST_PIN_LOW:
            begin
                d.cnt = q.cnt + 1'b1;
                if (at_last(q.cnt, PIN_LOW_LAST))
                begin
                    d.st = ST_HOLD;
                    d.cnt = '0;
                    d.pin_drive = 1'b0;
                end
            end
            ST_HOLD:
            begin
                d.cnt = q.cnt + 1'b1;
                if (at_last(q.cnt, HOLD_LAST))
                begin
                    // Pin still low 32 cycles after our release means someone else holds it
                    if (!q.pin_lvl && !q.ext_hit)
                    begin
                        sets[PIN_BIT] = 1'b1;
                    end
                    d.st = ST_RUN;
                    d.ext_hit = 1'b0;
                    d.out.cpu_reset = 1'b0;
                    d.out.bus_div4_force = 1'b0;
                    d.out.vector_load = 1'b1;
                end
            end
        endcase

        // Low supply overrides every other step and restarts the long delay
        if (q.sup_lvl && (q.st != ST_SUPPLY))
        begin
            sets[LOW_SUP_BIT] = 1'b1;
            d.st = ST_SUPPLY;
            d.cnt = '0;
            d.ext_hit = 1'b0;
            d.pin_drive = 1'b1;
            d.out.clocks_gated = 1'b1;
            d.out.cpu_reset = 1'b1;
            d.out.vector_load = 1'b0; // No vector fetch while the supply drags us back
        end

        // A rise of cpu_reset re-phases the divider and forces the slow bus clock
        if (d.out.cpu_reset && !q.out.cpu_reset)
        begin
            d.div_cnt = 2'h0;
            d.out.bus_clk_en = 1'b0;
            d.out.bus_div4_force = 1'b1;
        end

        // Avalon slave: first cycle prepares data, second cycle commits
        commit = (av_req.read | av_req.write) & ~q.rsp.waitrequest;
        commit_rd_cause = commit & av_req.read & (av_req.address == CAUSE_OFS);
        d.rsp.waitrequest = 1'b1;
        if ((av_req.read | av_req.write) && q.rsp.waitrequest)
        begin
            d.rsp.waitrequest = 1'b0;
            d.rsp.readdata = 32'h0000_0000;
            if (av_req.read && av_req.address == CAUSE_OFS)
            begin
                d.rsp.readdata = {24'h00_0000, q.flags};
            end
            else if (av_req.read && av_req.address == CTRL_OFS)
            begin
                d.rsp.readdata = {31'h0000_0000, q.stop_en};
            end
        end
        if (commit && av_req.write && av_req.address == WDOG_OFS)
        begin
            d.out.watchdog_clear = 1'b1;
        end
        if (commit && av_req.write && av_req.address == CTRL_OFS && av_req.byteenable[0])
        begin
            d.stop_en = av_req.writedata[CTRL_STOP_EN_BIT];
        end

        // Only bits that were actually returned are cleared; a new set wins
        if (commit_rd_cause)
        begin
            d.flags = q.flags & ~q.rsp.readdata[7:0];
        end
        d.flags = d.flags | sets;
    end

    // ****************************************************************
    // State register; power-on starts the stabilisation delay
    // ****************************************************************
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            q.st <= ST_STAB;
            q.cnt <= '0;
            q.flags <= FLAGS_RST;
            q.ext_hit <= 1'b0;
            q.pin_drive <= 1'b1;
            q.pin_sync <= 3'h7;
            q.pin_lvl <= 1'b1;
            q.sup_sync <= 3'h0;
            q.sup_lvl <= 1'b0;
            q.div_cnt <= 2'h0;
            q.stop_en <= CTRL_STOP_EN_RST;
            q.rsp <= '{readdata: 32'h0000_0000, waitrequest: 1'b1};
            q.out <= '{cpu_reset: 1'b1, clocks_gated: 1'b1, vector_load: 1'b0,
                       vector_addr: RESET_VECTOR_ADDR, bus_clk_en: 1'b0,
                       bus_div4_force: 1'b1, watchdog_clear: 1'b0};
        end
        else
        begin
            q <= d;
        end
    end

    // Open-drain pin: only ever pulled low
    assign rst_n_pin_out = 1'b0;
    assign rst_n_pin_oe = q.pin_drive;
    assign av_rsp = q.rsp;
    assign seq_out = q.out;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    logic [CNT_W:0] stab_h;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            stab_h <= '0;
        end
        else
        begin
            stab_h <= (q.st == ST_STAB) ? stab_h + 1'b1 : '0;
        end
    end

    sequence pin_released_s;
        $fell(rst_n_pin_oe);
    endsequence

    sequence cpu_freed_s;
        $fell(seq_out.cpu_reset) && seq_out.vector_load;
    endsequence

    pin_low_len_a: assert property (pin_released_s |-> $past(rst_n_pin_oe, 32))
        else $error("pin released before 32 low cycles");
    hold_len_a: assert property (pin_released_s |-> ##32 cpu_freed_s)
        else $error("cpu not released 32 cycles after pin");
    hold_keep_a: assert property (pin_released_s |-> seq_out.cpu_reset [*8])
        else $error("cpu left reset too early after pin release");
    stab_len_a: assert property (
        (q.st == ST_STAB) && (d.st == ST_PIN_LOW) |-> stab_h == (CNT_W+1)'(STAB_CYCLES - 1))
        else $error("stabilisation delay not 4096 cycles");
    vector_load_a: assert property (
        $fell(seq_out.cpu_reset) |-> seq_out.vector_load && (seq_out.vector_addr == 16'hFFFE))
        else $error("cpu released without vector load from reset vector");
    div_force_a: assert property ($rose(seq_out.cpu_reset) |-> seq_out.bus_div4_force)
        else $error("bus clock not forced slow in reset");
    read_clear_a: assert property (
        commit_rd_cause && (sets == 8'h00) |=> (q.flags & $past(q.rsp.readdata[7:0])) == 8'h00)
        else $error("read did not clear flags");
    sticky_a: assert property (
        !commit_rd_cause |=> (q.flags & $past(q.flags)) == $past(q.flags))
        else $error("flag lost without a read");
    wdog_flag_a: assert property (
        (q.st == ST_RUN) && cpu_events.watchdog_overflow && !q.sup_lvl
        |=> q.flags[WDOG_BIT] && rst_n_pin_oe)
        else $error("watchdog overflow not recorded");
    stop_bad_a: assert property (
        (q.st == ST_RUN) && cpu_events.stop_executed && !q.stop_en && !q.sup_lvl
        |=> q.flags[BAD_OP_BIT])
        else $error("disabled stop not treated as bad opcode");
    wdog_clear_a: assert property (
        commit && av_req.write && (av_req.address == WDOG_OFS) |=> seq_out.watchdog_clear)
        else $error("watchdog write did not clear counter");
    supply_hold_a: assert property (q.sup_lvl |=> rst_n_pin_oe && seq_out.clocks_gated)
        else $error("pin not held during low supply");

endmodule

// ### shared/reset_seq_pkg.sv
package reset_seq_pkg;

    // ****************************************************************
    // Clock and sequence timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int STAB_CYCLES = 4096;
    localparam int PIN_LOW_CYCLES = 32;
    localparam int HOLD_CYCLES = 32;
    localparam int CNT_W = 13;
    localparam logic [CNT_W-1:0] STAB_LAST = CNT_W'(STAB_CYCLES - 1);
    localparam logic [CNT_W-1:0] PIN_LOW_LAST = CNT_W'(PIN_LOW_CYCLES - 1);
    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);
    localparam logic [1:0] BUS_DIV_LAST = 2'h3;

    // ****************************************************************
    // Register map (byte offsets on the Avalon slave)
    // ****************************************************************
    localparam logic [3:0] CAUSE_OFS = 4'h0;
    localparam logic [3:0] WDOG_OFS = 4'h4;
    localparam logic [3:0] CTRL_OFS = 4'h8;
    localparam int CTRL_STOP_EN_BIT = 0;
    localparam logic CTRL_STOP_EN_RST = 1'b0;

    // ****************************************************************
    // Reset cause flag positions
    // ****************************************************************
    localparam int POR_BIT = 7;
    localparam int PIN_BIT = 6;
    localparam int WDOG_BIT = 5;
    localparam int BAD_OP_BIT = 4;
    localparam int BAD_FETCH_BIT = 3;
    localparam int MON_BIT = 2;
    localparam int LOW_SUP_BIT = 1;
    localparam logic [7:0] FLAGS_RST = 8'h80;

    // ****************************************************************
    // Reset vector
    // ****************************************************************
    localparam logic [15:0] RESET_VECTOR_ADDR = 16'hFFFE;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic [3:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } av_req_s;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } av_rsp_s;

    typedef struct packed {
        logic watchdog_overflow;
        logic bad_opcode;
        logic stop_executed;
        logic fetch_unmapped;
        logic monitor_entry;
    } cpu_events_s;

    typedef struct packed {
        logic cpu_reset;
        logic clocks_gated;
        logic vector_load;
        logic [15:0] vector_addr;
        logic bus_clk_en;
        logic bus_div4_force;
        logic watchdog_clear;
    } seq_out_s;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_SUPPLY,
        ST_STAB,
        ST_PIN_LOW,
        ST_HOLD,
        ST_EXT
    } seq_state_e;

endpackage

// ### sim/ext_reset_device.sv
`timescale 1ns/1ps
// ****************************************************************
// Other party on the shared open-drain reset line
// ****************************************************************
module ext_reset_device (
    // Device side of the line
    input wire logic rst_n_pin_out,
    input wire logic rst_n_pin_oe,
    // Bench command: pull the line low, for as short or long as it likes
    input wire logic hold_low,
    // Resolved line level
    output logic pin_level
);
    // Pull-up wins unless a party pulls low; a long enough pull is a reset
    assign pin_level = !((rst_n_pin_oe && !rst_n_pin_out) || hold_low);
endmodule

// ### sim/tb.sv
`timescale 1ns/1ps
module tb;
    import reset_seq_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic supply_low = 1'b0;
    logic hold_low = 1'b0;
    logic pin_level;
    logic rst_n_pin_out;
    logic rst_n_pin_oe;
    av_req_s av_req = '0;
    av_rsp_s av_rsp;
    cpu_events_s cpu_events = '0;
    seq_out_s seq_out;
    int failures = 0;
    int n_compared = 0;
    logic [31:0] rd;
    int g;
    int p;
    int h;
    logic [4:0] ev_tab [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
    int bit_tab [5] = '{WDOG_BIT, BAD_OP_BIT, BAD_OP_BIT, BAD_FETCH_BIT, MON_BIT};

    // ****************************************************************
    // Clock, design and far side
    // ****************************************************************
    // 200 MHz reference clock
    always #2.5 sys_clk = ~sys_clk;

    reset_source_sequencer reset_source_sequencer_i (
        .sys_clk(sys_clk), .rst(rst), .av_req(av_req), .av_rsp(av_rsp),
        .cpu_events(cpu_events), .supply_low(supply_low), .rst_n_pin_in(pin_level),
        .rst_n_pin_out(rst_n_pin_out), .rst_n_pin_oe(rst_n_pin_oe), .seq_out(seq_out));

    ext_reset_device ext_reset_device_i (.rst_n_pin_out(rst_n_pin_out),
        .rst_n_pin_oe(rst_n_pin_oe), .hold_low(hold_low), .pin_level(pin_level));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("FAIL t=%0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // One access; the request stands until waitrequest is seen low
    // No cycle budget here: a hung slave is caught by the watchdog alone
    task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] wd);
        av_req <= '{address: a, read: !wr, write: wr, writedata: wd, byteenable: 4'hF};
        tick(1);
        while (av_rsp.waitrequest !== 1'b0)
        begin
            tick(1);
        end
        rd = av_rsp.readdata;
        av_req <= '0;
        tick(1);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
        bus(a, 1'b0, 32'h0000_0000);
        check(rd, exp, what);
    endtask

    // Times gated, pin-low and hold phases from the current edge
    task automatic phases();
        g = 0;
        p = 0;
        h = 0;
        while (seq_out.clocks_gated === 1'b1 && g < 9000)
        begin
            tick(1);
            g++;
        end
        while (rst_n_pin_oe === 1'b1 && p < 9000)
        begin
            tick(1);
            p++;
        end
        while (seq_out.cpu_reset === 1'b1 && h < 9000)
        begin
            tick(1);
            h++;
        end
        check(seq_out.vector_load, 1'b1, "vector load");
        check(seq_out.vector_addr, RESET_VECTOR_ADDR, "vector addr");
        check(seq_out.bus_div4_force, 1'b0, "div4 off");
    endtask

    // Pulses one event and checks the 32 + 32 internal timing
    task automatic internal(input logic [4:0] ev);
        int n;
        int e;
        n = 0;
        e = 0;
        cpu_events <= ev;
        tick(1);
        cpu_events <= '0;
        while (rst_n_pin_oe !== 1'b1 && n < 5)
        begin
            tick(1);
            n++;
        end
        check(n, 1, "answer");
        check(seq_out.cpu_reset, 1'b1, "cpu held");
        check(seq_out.bus_div4_force, 1'b1, "div4 on");
        repeat (8)
        begin
            tick(1);
            e += int'(seq_out.bus_clk_en === 1'b1);
        end
        check(e, 2, "ref/4 enable");
        phases();
        check(p + 8, PIN_LOW_CYCLES, "pin low");
        check(h, HOLD_CYCLES, "hold");
    endtask

    // Power-on or supply style sequence, then the flags
    task automatic long_seq(input int slack, input logic [31:0] flags);
        phases();
        check(int'(g >= STAB_CYCLES - 1 && g <= STAB_CYCLES + slack), 1, "stab");
        check(p, PIN_LOW_CYCLES, "pin low");
        check(h, HOLD_CYCLES, "hold");
        rd_chk(CAUSE_OFS, flags, "cause after long");
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_por();
        check(seq_out.clocks_gated & rst_n_pin_oe, 1'b1, "por gated");
        long_seq(1, 32'h0000_0080);
        rd_chk(CAUSE_OFS, 32'h0000_0000, "read clears");
        rd_chk(4'hC, 32'h0000_0000, "unmapped");
        $display("test power-on done");
    endtask

    task automatic t_events();
        for (int i = 0; i < 5; i++)
        begin
            internal(ev_tab[i]);
            rd_chk(CAUSE_OFS, 32'h0000_0001 << bit_tab[i], "cause");
        end
        internal(5'h10);
        internal(5'h02);
        rd_chk(CAUSE_OFS, 32'h0000_0028, "accumulate");
        $display("test events done");
    endtask

    task automatic t_regs();
        internal(5'h10);
        bus(CAUSE_OFS, 1'b1, 32'h0000_00FF);
        bus(WDOG_OFS, 1'b1, 32'hA5A5_A5A5);
        check(seq_out.watchdog_clear, 1'b1, "wdog clear");
        tick(1);
        check(seq_out.watchdog_clear, 1'b0, "wdog clear end");
        rd_chk(CAUSE_OFS, 32'h0000_0020, "write keeps");
        bus(CTRL_OFS, 1'b1, 32'h0000_0001);
        rd_chk(CTRL_OFS, 32'h0000_0001, "ctrl");
        cpu_events <= 5'h04;
        tick(1);
        cpu_events <= '0;
        tick(4);
        check(rst_n_pin_oe, 1'b0, "stop allowed");
        bus(CTRL_OFS, 1'b1, 32'h0000_0000);
        $display("test registers done");
    endtask

    task automatic t_ext();
        int n;
        n = 0;
        hold_low <= 1'b1;
        tick(10);
        hold_low <= 1'b0;
        tick(30);
        check(seq_out.cpu_reset, 1'b0, "glitch");
        hold_low <= 1'b1;
        tick(40);
        check(seq_out.cpu_reset, 1'b1, "ext held");
        hold_low <= 1'b0;
        while (seq_out.cpu_reset === 1'b1 && n < 100)
        begin
            tick(1);
            n++;
        end
        // Pin synchroniser and the step out of the external wait come before the hold
        check(int'(n >= HOLD_CYCLES + 4 && n <= HOLD_CYCLES + 8), 1, "ext hold");
        rd_chk(CAUSE_OFS, 32'h0000_0040, "pin flag");
        // Slow party keeps the line low past the device's release
        hold_low <= 1'b1;
        internal(5'h10);
        hold_low <= 1'b0;
        tick(40);
        rd_chk(CAUSE_OFS, 32'h0000_0060, "late pin");
        $display("test external done");
    endtask

    task automatic t_power();
        supply_low <= 1'b1;
        tick(40);
        check(rst_n_pin_oe & seq_out.clocks_gated, 1'b1, "low supply");
        supply_low <= 1'b0;
        // Recovery passes the supply synchroniser before the long delay starts
        long_seq(8, 32'h0000_0001 << LOW_SUP_BIT);
        internal(5'h10);
        rst <= 1'b1;
        tick(2);
        rst <= 1'b0;
        tick(1);
        long_seq(1, 32'h0000_0080);
        $display("test supply and power-on again done");
    endtask

    // ****************************************************************
    // Sequence, verdict and watchdog
    // ****************************************************************
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        tick(10);
        rst <= 1'b0;
        tick(1);
        t_por();
        t_events();
        t_regs();
        t_ext();
        t_power();
        test_done();
    end

    // Three long sequences plus short ones fit well inside this span
    initial
    begin
        #200000;
        failures++;
        test_done();
    end
endmodule
